// ---- rtl/ebps_pin_route.sv ----
// Generic registered N-way pin router: one source group per mode
`timescale 1ns/1ns
`default_nettype none

module ebps_pin_route #(
  parameter int PINS = 21,
  parameter int MODES = 8,
  parameter int SEL_W = 3
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [SEL_W-1:0] i_sel,
  input wire logic [MODES*PINS-1:0] i_src_out,
  input wire logic [MODES*PINS-1:0] i_src_oe,
  input wire logic [PINS-1:0] i_pin_in,
  output logic [PINS-1:0] o_pin_out,
  output logic [PINS-1:0] o_pin_oe,
  output logic [MODES*PINS-1:0] o_src_in
);

  if (MODES < 1 || MODES > (1 << SEL_W) || PINS < 1) begin
    $error("ebps_pin_route: select too narrow or no pins");
  end

  logic [PINS-1:0] out_q;
  logic [PINS-1:0] oe_q;
  logic [MODES*PINS-1:0] src_in_q;
  wire logic [PINS-1:0] out_d = (int'(i_sel) < MODES) ? i_src_out[int'(i_sel)*PINS +: PINS] : '0;
  wire logic [PINS-1:0] oe_d = (int'(i_sel) < MODES) ? i_src_oe[int'(i_sel)*PINS +: PINS] : '0;

  // Only the selected peripheral sees the pins; others see idle zero
  logic [MODES*PINS-1:0] src_in_d;
  always_comb begin
    src_in_d = '0;
    for (int m = 0; m < MODES; m++) begin
      if (int'(i_sel) == m) begin
        src_in_d[m*PINS +: PINS] = i_pin_in;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      out_q <= '0;
      oe_q <= '0;
      src_in_q <= '0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      src_in_q <= src_in_d;
    end
  end

  assign o_pin_out = out_q;
  assign o_pin_oe = oe_q;
  assign o_src_in = src_in_q;

endmodule

`default_nettype wire

// ---- rtl/ebps_pkg.sv ----
// Package: register address, field layout, reset values and route modes for the bus pin selector
package ebps_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] EBPS_ROUTE_SEL_ADDR = 16'h1c00;
  localparam int EBPS_DATA_W = 16;
  localparam logic [15:0] EBPS_ROUTE_SEL_RESET = 16'h0000;
  localparam logic [15:0] EBPS_WRITABLE_MASK = 16'h7f3f;

  // ==========================================================================
  // Field positions
  localparam int EBPS_PP_LSB = 12;
  localparam int EBPS_PP_W = 3;
  localparam int EBPS_SP1_LSB = 10;
  localparam int EBPS_SP0_LSB = 8;
  localparam int EBPS_SP_W = 2;
  localparam int EBPS_ADDR_SEL_LSB = 0;
  localparam int EBPS_ADDR_PINS = 6;

  // ==========================================================================
  // Pin counts
  localparam int EBPS_PP_PINS = 21;
  localparam int EBPS_SP_PINS = 6;

  typedef enum logic [2:0] {
    EBPS_PP_MODE0 = 3'h0,
    EBPS_PP_MODE1 = 3'h1,
    EBPS_PP_MODE2 = 3'h2,
    EBPS_PP_MODE3 = 3'h3,
    EBPS_PP_MODE4 = 3'h4,
    EBPS_PP_MODE5 = 3'h5,
    EBPS_PP_MODE6 = 3'h6,
    EBPS_PP_MODE7 = 3'h7
  } ebps_pp_mode_t;

  typedef enum logic [1:0] {
    EBPS_SP_MMC = 2'h0,
    EBPS_SP_I2S = 2'h1,
    EBPS_SP_GPIO = 2'h2,
    EBPS_SP_RSVD = 2'h3
  } ebps_sp_mode_t;

endpackage

// ---- rtl/ebps_top.sv ----
// External bus pin selector: route select register and pin multiplexers
`timescale 1ns/1ns
`default_nettype none

module ebps_top
  import ebps_pkg::*;
#(
  parameter int PP_MODES = 8,
  parameter int SP_MODES = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  // CPU I/O space port
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [ebps_pkg::EBPS_DATA_W-1:0] i_io_wdata,
  output logic [ebps_pkg::EBPS_DATA_W-1:0] o_io_rdata,
  output logic o_io_rvalid,
  // Parallel port: per-mode peripheral sources, flat by mode
  input wire logic [PP_MODES*ebps_pkg::EBPS_PP_PINS-1:0] i_pp_src_out,
  input wire logic [PP_MODES*ebps_pkg::EBPS_PP_PINS-1:0] i_pp_src_oe,
  output logic [PP_MODES*ebps_pkg::EBPS_PP_PINS-1:0] o_pp_src_in,
  input wire logic [ebps_pkg::EBPS_PP_PINS-1:0] i_pp_pin,
  output logic [ebps_pkg::EBPS_PP_PINS-1:0] o_pp_pin,
  output logic [ebps_pkg::EBPS_PP_PINS-1:0] o_pp_pin_oe,
  // Serial port 0
  input wire logic [SP_MODES*ebps_pkg::EBPS_SP_PINS-1:0] i_sp0_src_out,
  input wire logic [SP_MODES*ebps_pkg::EBPS_SP_PINS-1:0] i_sp0_src_oe,
  output logic [SP_MODES*ebps_pkg::EBPS_SP_PINS-1:0] o_sp0_src_in,
  input wire logic [ebps_pkg::EBPS_SP_PINS-1:0] i_sp0_pin,
  output logic [ebps_pkg::EBPS_SP_PINS-1:0] o_sp0_pin,
  output logic [ebps_pkg::EBPS_SP_PINS-1:0] o_sp0_pin_oe,
  // Serial port 1
  input wire logic [SP_MODES*ebps_pkg::EBPS_SP_PINS-1:0] i_sp1_src_out,
  input wire logic [SP_MODES*ebps_pkg::EBPS_SP_PINS-1:0] i_sp1_src_oe,
  output logic [SP_MODES*ebps_pkg::EBPS_SP_PINS-1:0] o_sp1_src_in,
  input wire logic [ebps_pkg::EBPS_SP_PINS-1:0] i_sp1_pin,
  output logic [ebps_pkg::EBPS_SP_PINS-1:0] o_sp1_pin,
  output logic [ebps_pkg::EBPS_SP_PINS-1:0] o_sp1_pin_oe,
  // Upper address pins 20..15 (bit 0 is pin 15)
  input wire logic [ebps_pkg::EBPS_ADDR_PINS-1:0] i_external_memory_interface_addr,
  input wire logic [ebps_pkg::EBPS_ADDR_PINS-1:0] i_addr_gpio_out,
  input wire logic [ebps_pkg::EBPS_ADDR_PINS-1:0] i_addr_gpio_oe,
  input wire logic [ebps_pkg::EBPS_ADDR_PINS-1:0] i_ext_mem_addr_pin,
  output logic [ebps_pkg::EBPS_ADDR_PINS-1:0] o_ext_mem_addr_pin,
  output logic [ebps_pkg::EBPS_ADDR_PINS-1:0] o_ext_mem_addr_pin_oe,
  output logic [ebps_pkg::EBPS_ADDR_PINS-1:0] o_addr_gpio_in,
  // Current field values for observation
  output logic [ebps_pkg::EBPS_PP_W-1:0] o_parallel_port_route_sel,
  output logic [ebps_pkg::EBPS_SP_W-1:0] o_serial_port1_route_sel,
  output logic [ebps_pkg::EBPS_SP_W-1:0] o_serial_port0_route_sel
);

  import ebps_pkg::*;

  // Each mode count must fit its select field
  if (PP_MODES < 1 || PP_MODES > (1 << EBPS_PP_W)) begin
    $error("ebps_top: PP_MODES does not fit its select field");
  end
  if (SP_MODES < 1 || SP_MODES > (1 << EBPS_SP_W)) begin
    $error("ebps_top: SP_MODES does not fit its select field");
  end

  // ==========================================================================
  // Register access
  logic [EBPS_DATA_W-1:0] bus_route_select_reg_q;
  logic [EBPS_DATA_W-1:0] rdata_q;
  logic rvalid_q;

  wire logic hit = (i_io_addr == EBPS_ROUTE_SEL_ADDR);
  wire logic wr_hit = hit & i_io_wr;
  // Bit 15 and 7:6 are never stored
  wire logic [EBPS_DATA_W-1:0] reg_d = wr_hit ? (i_io_wdata & EBPS_WRITABLE_MASK) : bus_route_select_reg_q;
  // Unmapped reads return zero
  wire logic [EBPS_DATA_W-1:0] rdata_d = hit ? bus_route_select_reg_q : '0;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bus_route_select_reg_q <= EBPS_ROUTE_SEL_RESET;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      bus_route_select_reg_q <= reg_d;
      rdata_q <= i_io_rd ? rdata_d : '0;
      rvalid_q <= i_io_rd;
    end
  end

  assign o_io_rdata = rdata_q;
  assign o_io_rvalid = rvalid_q;

  // ==========================================================================
  // Field extraction
  wire logic [EBPS_PP_W-1:0] parallel_port_route_sel = bus_route_select_reg_q[EBPS_PP_LSB +: EBPS_PP_W];
  wire logic [EBPS_SP_W-1:0] serial_port1_route_sel = bus_route_select_reg_q[EBPS_SP1_LSB +: EBPS_SP_W];
  wire logic [EBPS_SP_W-1:0] serial_port0_route_sel = bus_route_select_reg_q[EBPS_SP0_LSB +: EBPS_SP_W];
  wire logic [EBPS_ADDR_PINS-1:0] addr_gpio_sel = bus_route_select_reg_q[EBPS_ADDR_SEL_LSB +: EBPS_ADDR_PINS];

  assign o_parallel_port_route_sel = parallel_port_route_sel;
  assign o_serial_port1_route_sel = serial_port1_route_sel;
  assign o_serial_port0_route_sel = serial_port0_route_sel;

  // ==========================================================================
  // Pin level synchronisers
  // Pins are asynchronous to the CPU clock; two flops guard against
  // metastability, at the cost of two cycles of input latency.
  logic [EBPS_PP_PINS-1:0] pp_pin_meta_q;
  logic [EBPS_PP_PINS-1:0] pp_pin_sync_q;
  logic [EBPS_SP_PINS-1:0] sp0_pin_meta_q;
  logic [EBPS_SP_PINS-1:0] sp0_pin_sync_q;
  logic [EBPS_SP_PINS-1:0] sp1_pin_meta_q;
  logic [EBPS_SP_PINS-1:0] sp1_pin_sync_q;
  logic [EBPS_ADDR_PINS-1:0] addr_pin_meta_q;
  logic [EBPS_ADDR_PINS-1:0] addr_pin_sync_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pp_pin_meta_q <= '0;
      pp_pin_sync_q <= '0;
      sp0_pin_meta_q <= '0;
      sp0_pin_sync_q <= '0;
      sp1_pin_meta_q <= '0;
      sp1_pin_sync_q <= '0;
      addr_pin_meta_q <= '0;
      addr_pin_sync_q <= '0;
    end else begin
      pp_pin_meta_q <= i_pp_pin;
      pp_pin_sync_q <= pp_pin_meta_q;
      sp0_pin_meta_q <= i_sp0_pin;
      sp0_pin_sync_q <= sp0_pin_meta_q;
      sp1_pin_meta_q <= i_sp1_pin;
      sp1_pin_sync_q <= sp1_pin_meta_q;
      addr_pin_meta_q <= i_ext_mem_addr_pin;
      addr_pin_sync_q <= addr_pin_meta_q;
    end
  end

  // ==========================================================================
  // Pin routing; the register feeds a registered mux, so a write shows on pins
  // one clock after the register stores it. Software must gate and reset the
  // peripherals around a change no glitch filtering is done here.
  ebps_pin_route #(
    .PINS(EBPS_PP_PINS),
    .MODES(PP_MODES),
    .SEL_W(EBPS_PP_W)
  ) u_pp (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_sel(parallel_port_route_sel),
    .i_src_out(i_pp_src_out),
    .i_src_oe(i_pp_src_oe),
    .i_pin_in(pp_pin_sync_q),
    .o_pin_out(o_pp_pin),
    .o_pin_oe(o_pp_pin_oe),
    .o_src_in(o_pp_src_in)
  );

  ebps_pin_route #(
    .PINS(EBPS_SP_PINS),
    .MODES(SP_MODES),
    .SEL_W(EBPS_SP_W)
  ) u_sp0 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_sel(serial_port0_route_sel),
    .i_src_out(i_sp0_src_out),
    .i_src_oe(i_sp0_src_oe),
    .i_pin_in(sp0_pin_sync_q),
    .o_pin_out(o_sp0_pin),
    .o_pin_oe(o_sp0_pin_oe),
    .o_src_in(o_sp0_src_in)
  );

  ebps_pin_route #(
    .PINS(EBPS_SP_PINS),
    .MODES(SP_MODES),
    .SEL_W(EBPS_SP_W)
  ) u_sp1 (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_sel(serial_port1_route_sel),
    .i_src_out(i_sp1_src_out),
    .i_src_oe(i_sp1_src_oe),
    .i_pin_in(sp1_pin_sync_q),
    .o_pin_out(o_sp1_pin),
    .o_pin_oe(o_sp1_pin_oe),
    .o_src_in(o_sp1_src_in)
  );

  // ==========================================================================
  // Upper address pins: per-pin choice between memory address and GPIO
  logic [EBPS_ADDR_PINS-1:0] addr_out_q;
  logic [EBPS_ADDR_PINS-1:0] addr_oe_q;
  logic [EBPS_ADDR_PINS-1:0] addr_gin_q;
  wire logic [EBPS_ADDR_PINS-1:0] addr_out_d = (addr_gpio_sel & i_addr_gpio_out) | (~addr_gpio_sel & i_external_memory_interface_addr);
  // Address duty always drives; GPIO drives only when its enable is set
  wire logic [EBPS_ADDR_PINS-1:0] addr_oe_d = ~addr_gpio_sel | i_addr_gpio_oe;
  wire logic [EBPS_ADDR_PINS-1:0] addr_gin_d = addr_gpio_sel & addr_pin_sync_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      addr_out_q <= '0;
      addr_oe_q <= '1;
      addr_gin_q <= '0;
    end else begin
      addr_out_q <= addr_out_d;
      addr_oe_q <= addr_oe_d;
      addr_gin_q <= addr_gin_d;
    end
  end

  assign o_ext_mem_addr_pin = addr_out_q;
  assign o_ext_mem_addr_pin_oe = addr_oe_q;
  assign o_addr_gpio_in = addr_gin_q;

endmodule

`default_nettype wire

// ---- verification/ebps_top_monitor.sv ----
// Checker for the route select register and upper address pins
`timescale 1ns/1ns
`default_nettype none
module ebps_top_monitor
  import ebps_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [15:0] i_io_wdata,
  input wire logic [15:0] o_io_rdata,
  input wire logic o_io_rvalid,
  input wire logic [5:0] i_external_memory_interface_addr,
  input wire logic [5:0] i_addr_gpio_out,
  input wire logic [5:0] i_addr_gpio_oe,
  input wire logic [5:0] i_ext_mem_addr_pin,
  input wire logic [5:0] o_ext_mem_addr_pin,
  input wire logic [5:0] o_ext_mem_addr_pin_oe,
  input wire logic [5:0] o_addr_gpio_in,
  input wire logic [2:0] o_parallel_port_route_sel,
  input wire logic [1:0] o_serial_port1_route_sel,
  input wire logic [1:0] o_serial_port0_route_sel
);
  // ==========================================================================
  // Address select mirror, needed since those bits have no port
  logic [5:0] sel_q;
  wire hit = i_io_addr == EBPS_ROUTE_SEL_ADDR;
  wire [6:0] fld = {o_parallel_port_route_sel, o_serial_port1_route_sel, o_serial_port0_route_sel};
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) sel_q <= 6'h0;
    else if (i_io_wr && hit) sel_q <= i_io_wdata[5:0];
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_wr; i_io_wr && hit; endsequence
  // First edge after release still shows reset outputs
  sequence s_live; !$past(i_rst); endsequence
  chk_field_load: assert property (s_wr |=> fld == $past(i_io_wdata[14:8]))
    else $error("fields not loaded");
  chk_field_hold: assert property (!(i_io_wr && hit) |=> $stable(fld))
    else $error("fields changed");
  chk_rvalid_pulse: assert property (i_io_rd |=> o_io_rvalid)
    else $error("no read answer");
  chk_read_value: assert property (i_io_rd && hit && !i_io_wr |=>
    o_io_rdata == {1'b0, $past(fld), 2'h0, $past(sel_q)}) else $error("read value");
  chk_read_unmapped: assert property (i_io_rd && !hit |=> o_io_rdata == 16'h0000)
    else $error("unmapped read");
  chk_addr_external_memory_interface: assert property (s_live |-> ((o_ext_mem_addr_pin ^ $past(i_external_memory_interface_addr)) & ~$past(sel_q)) == 6'h0
    && (o_ext_mem_addr_pin_oe | $past(sel_q)) == 6'h3f) else $error("address pin");
  chk_addr_gpio: assert property (s_live |-> ((o_ext_mem_addr_pin ^ $past(i_addr_gpio_out)) & $past(sel_q)) == 6'h0
    && ((o_ext_mem_addr_pin_oe ^ $past(i_addr_gpio_oe)) & $past(sel_q)) == 6'h0) else $error("gpio pin");
  // Pin levels pass two synchroniser flops and the output flop
  sequence s_settled; !$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3); endsequence
  chk_gpio_in: assert property (s_settled |-> o_addr_gpio_in == ($past(i_ext_mem_addr_pin, 3) & $past(sel_q)))
    else $error("gpio input");
endmodule
bind ebps_top ebps_top_monitor u_mon (.i_mclk, .i_rst, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata,
  .o_io_rvalid, .i_external_memory_interface_addr, .i_addr_gpio_out, .i_addr_gpio_oe, .i_ext_mem_addr_pin, .o_ext_mem_addr_pin,
  .o_ext_mem_addr_pin_oe, .o_addr_gpio_in, .o_parallel_port_route_sel, .o_serial_port1_route_sel,
  .o_serial_port0_route_sel);
`default_nettype wire

// ---- verification/tb_ebps_top.sv ----
// Self-checking bench for the bus pin selector
`timescale 1ns/1ns
`default_nettype none
module tb_ebps_top;
  import ebps_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic wr_s = 1'b0, rd_s = 1'b0, rv_s;
  logic [15:0] adr = 16'h0, wd = 16'h0, rdt, lfsr = 16'hb02e;
  logic [488:0] rv = '0;
  logic [167:0] pp_in;
  logic [20:0] pp_p, pp_oe;
  logic [5:0] s0_p, s1_p, a_p, a_oe, a_gi, s0_oe, s1_oe;
  logic [23:0] s0_in, s1_in;
  int error_cnt = 0, comparisons = 0;
  initial forever #50 i_mclk = ~i_mclk;
  ebps_top dut (.i_mclk, .i_rst, .i_io_addr(adr), .i_io_wr(wr_s), .i_io_rd(rd_s), .i_io_wdata(wd),
    .o_io_rdata(rdt), .o_io_rvalid(rv_s), .i_pp_src_out(rv[167:0]), .i_pp_src_oe(rv[335:168]),
    .o_pp_src_in(pp_in), .i_pp_pin(rv[452:432]), .o_pp_pin(pp_p), .o_pp_pin_oe(pp_oe),
    .i_sp0_src_out(rv[359:336]), .i_sp0_src_oe(rv[383:360]), .o_sp0_src_in(s0_in), .i_sp0_pin(rv[458:453]),
    .o_sp0_pin(s0_p), .o_sp0_pin_oe(s0_oe), .i_sp1_src_out(rv[407:384]), .i_sp1_src_oe(rv[431:408]),
    .o_sp1_src_in(s1_in), .i_sp1_pin(rv[464:459]), .o_sp1_pin(s1_p), .o_sp1_pin_oe(s1_oe),
    .i_external_memory_interface_addr(rv[470:465]), .i_addr_gpio_out(rv[476:471]), .i_addr_gpio_oe(rv[482:477]),
    .i_ext_mem_addr_pin(rv[488:483]), .o_ext_mem_addr_pin(a_p), .o_ext_mem_addr_pin_oe(a_oe),
    .o_addr_gpio_in(a_gi), .o_parallel_port_route_sel(), .o_serial_port1_route_sel(),
    .o_serial_port0_route_sel());
  // ==========================================================================
  // Helpers
  function automatic logic [15:0] nxt();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic chk(string nm, logic [167:0] exp, logic [167:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge i_mclk);
    #5;
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    adr = a;
    wd = d;
    wr_s = 1'b1;
    step(1);
    wr_s = 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] exp);
    adr = a;
    rd_s = 1'b1;
    step(1);
    rd_s = 1'b0;
    chk("rvalid", 168'(1'b1), 168'(rv_s));
    chk("rdata", 168'(exp), 168'(rdt));
    // Let an edge pass so a following read never re-raises the strobe at once
    step(1);
  endtask
  // ==========================================================================
  // Route one setting, then compare every routed pin group
  task automatic route(logic [15:0] d);
    logic [5:0] s;
    int m;
    s = d[5:0];
    m = d[14:12];
    // Each setting is one boot: reset, peripherals quiet, a single write
    i_rst = 1'b1;
    step(2);
    i_rst = 1'b0;
    rv[431:0] = '0;
    wr(EBPS_ROUTE_SEL_ADDR, d);
    for (int k = 0; k < 31; k++) rv = {rv[472:0], nxt()};
    // Pin levels need two synchroniser flops ahead of the router flop
    step(3);
    chk("pp_pin", 168'(rv[m*21+:21]), 168'(pp_p));
    chk("pp_oe", 168'(rv[168+m*21+:21]), 168'(pp_oe));
    chk("pp_in", 168'(rv[452:432]) << (m * 21), pp_in);
    chk("sp1_pin", 168'(rv[384+d[11:10]*6+:6]), 168'(s1_p));
    chk("sp0_pin", 168'(rv[336+d[9:8]*6+:6]), 168'(s0_p));
    chk("sp1_oe", 168'(rv[408+d[11:10]*6+:6]), 168'(s1_oe));
    chk("sp0_oe", 168'(rv[360+d[9:8]*6+:6]), 168'(s0_oe));
    chk("sp1_in", 168'(rv[464:459]) << (d[11:10] * 6), 168'(s1_in));
    chk("sp0_in", 168'(rv[458:453]) << (d[9:8] * 6), 168'(s0_in));
    chk("addr_pin", 168'(rv[470:465] & ~s | rv[476:471] & s), 168'(a_p));
    chk("addr_oe", 168'(6'(~s | rv[482:477] & s)), 168'(a_oe));
    chk("gpio_in", 168'(rv[488:483] & s), 168'(a_gi));
  endtask
  task automatic close_out();
    $display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    logic [15:0] d;
    step(12);
    i_rst = 1'b0;
    rd(EBPS_ROUTE_SEL_ADDR, 16'h0000);
    wr(EBPS_ROUTE_SEL_ADDR, 16'hffff);
    rd(EBPS_ROUTE_SEL_ADDR, 16'h7f3f);
    wr(16'h1c01, 16'h0000);
    rd(EBPS_ROUTE_SEL_ADDR, 16'h7f3f);
    rd(16'h1c01, 16'h0000);
    // Every parallel and serial mode, with both select extremes
    for (int i = 0; i < 16; i++) begin
      d = nxt();
      d[14:8] = {i[2:0], i[1:0], i[3:2]};
      if (i == 0) d[5:0] = 6'h00;
      if (i == 15) d[5:0] = 6'h3f;
      route(d);
      rd(EBPS_ROUTE_SEL_ADDR, d & 16'h7f3f);
    end
    close_out();
  end
  initial begin
    repeat (2000) @(posedge i_mclk);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
